// ### core/dsp_defines.svh
// Constants of the dual serial register host port.
// Assumes inclusion by the design file only.
`ifndef DSP_DEFINES_SVH
`define DSP_DEFINES_SVH
`define DSP_CHIP_OWN_HI 3'h4
`define DSP_CHIP_BCAST 5'h15
`define DSP_SPI_DIR_BIT 5
`define DSP_I2C_FM_KHZ 400
`define DSP_I2C_FMP_KHZ 1000
`define DSP_SPI_MAX_KHZ 12000
`define DSP_CLK_KHZ 250000
// Idle pin levels {select, strap lo, strap hi, scl, sda, sclk, ss_n, mosi}
`define DSP_PIN_IDLE 8'h7A
`endif

// ### core/dsp_pkg.sv
// Types shared by the host port.
// Assumes dsp_defines.svh is available.
package dsp_pkg;
  typedef logic [9:0] dsp_addr_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } dsp_req_s;
endpackage : dsp_pkg

// ### core/dsp_host_port.sv
// Dual serial (I2C follower / SPI follower) register host port.
// Assumes a register file answering reads combinationally on reg_rdata_in.
// How it works
// [RULE_01] Select pin high gives SPI, low I2C
// [RULE_02] Sampled at 250 MHz, fine to 1 MHz
// [RULE_03] SDA changes only while SCL is low
// [RULE_04] Repeated start handled like first start
// [RULE_05] Bus busy from start until stop
// [RULE_06] Acknowledge each received byte on ninth clock
// [RULE_07] Leader NACK ends read data
// [RULE_08] Byte one: chip, addr 9..8, direction
// [RULE_09] Own address 100+straps, broadcast 10101
// [RULE_10] Byte two carries address bits 7..0
// [RULE_11] Address auto-increments after each data byte
// [RULE_12] Two straps give four distinct addresses
// [RULE_13] SPI follower only, up to 12 MHz
// [RULE_14] MISO driven only during reads, select low
// [RULE_15] Select high resets SPI state
// [RULE_16] Sample on SCLK rise, launch on fall
// [RULE_17] SPI byte one holds address 9..2
// [RULE_18] SPI byte two: addr 1..0, direction, ignored
// [RULE_19] Host gives each device its own select
// [RULE_20] Data bytes write or read, then advance
`include "dsp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dsp_host_port (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic interface_select_pin_in,
  input wire logic chip_address_strap_low_in,
  input wire logic chip_address_strap_high_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic sclk_in,
  input wire logic ss_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_n_out,
  output var dsp_pkg::dsp_req_s req_out,
  input wire logic [7:0] reg_rdata_in,
  output logic bus_busy_out
);
  import dsp_pkg::*;

  // Two-stage synchronisers for all pins
  logic [7:0] s1_reg;
  logic [7:0] s2_reg;
  logic [7:0] s3_reg;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg <= `DSP_PIN_IDLE; // Idle levels, so no false edge after reset
      s2_reg <= `DSP_PIN_IDLE;
      s3_reg <= `DSP_PIN_IDLE;
    end else begin
      s1_reg <= {interface_select_pin_in, chip_address_strap_low_in,
                 chip_address_strap_high_in, scl_in, sda_in, sclk_in, ss_n_in, mosi_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  logic spi_mode;
  logic strap_lo;
  logic strap_hi;
  logic scl;
  logic sda;
  logic sclk;
  logic ss_n;
  logic mosi;
  assign spi_mode = s2_reg[7]; // RULE_01
  assign strap_lo = s2_reg[6];
  assign strap_hi = s2_reg[5];
  assign scl = s2_reg[4];
  assign sda = s2_reg[3];
  assign sclk = s2_reg[2];
  assign ss_n = s2_reg[1];
  assign mosi = s2_reg[0];

  // Edge and condition detection on synchronised copies
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  logic sclk_rise;
  logic sclk_fall;
  assign scl_rise = scl & ~s3_reg[4]; // RULE_02
  assign scl_fall = ~scl & s3_reg[4];
  assign i2c_start = scl & s3_reg[4] & ~sda & s3_reg[3]; // RULE_04
  assign i2c_stop = scl & s3_reg[4] & sda & ~s3_reg[3];
  assign sclk_rise = sclk & ~s3_reg[2]; // RULE_16
  assign sclk_fall = ~sclk & s3_reg[2];

  // Own chip address from straps plus broadcast
  function automatic logic chip_match(input logic [4:0] c, input logic lo, input logic hi);
    chip_match = (c == {`DSP_CHIP_OWN_HI, hi, lo}) || (c == `DSP_CHIP_BCAST);
  endfunction : chip_match

  typedef enum {I_IDLE, I_CHIP_ADDRESS_STRAP_HIGH, I_ADDR2, I_WDATA, I_RDATA} dsp_i2c_e;
  dsp_i2c_e ist_reg;
  logic [3:0] ibit_reg;
  logic [7:0] ish_reg;
  logic ird_reg;
  logic iack_reg;
  logic [9:0] iaddr_reg;
  logic [7:0] iout_reg;
  logic req_wr_next;
  logic req_rd_next;
  logic [9:0] req_addr_next;
  logic [7:0] req_data_next;

  // I2C follower state machine, bit counted on SCL rise, SDA driven after SCL fall
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ist_reg <= I_IDLE;
      ibit_reg <= 4'h0;
      ish_reg <= 8'h00;
      ird_reg <= 1'b0;
      iack_reg <= 1'b0;
      iaddr_reg <= 10'h000;
      iout_reg <= 8'hFF;
      sda_oe_n_out <= 1'b1;
      bus_busy_out <= 1'b0;
    end else if (spi_mode) begin
      ist_reg <= I_IDLE;
      sda_oe_n_out <= 1'b1;
      bus_busy_out <= 1'b0;
    end else if (i2c_start) begin
      ist_reg <= I_CHIP_ADDRESS_STRAP_HIGH; // RULE_04
      ibit_reg <= 4'h0;
      sda_oe_n_out <= 1'b1;
      bus_busy_out <= 1'b1; // RULE_05
    end else if (i2c_stop) begin
      ist_reg <= I_IDLE;
      sda_oe_n_out <= 1'b1;
      bus_busy_out <= 1'b0; // RULE_05
    end else if (ist_reg != I_IDLE) begin
      if (scl_rise) begin
        if (ibit_reg == 4'h8) begin
          ibit_reg <= 4'h0;
          if (ist_reg == I_RDATA && sda) begin
            ist_reg <= I_IDLE; // RULE_07
          end
        end else begin
          ish_reg <= {ish_reg[6:0], sda};
          ibit_reg <= ibit_reg + 4'h1;
        end
      end
      if (scl_fall) begin
        if (ibit_reg == 4'h8 && ist_reg != I_RDATA) begin
          iack_reg <= 1'b1;
          case (ist_reg)
            I_CHIP_ADDRESS_STRAP_HIGH: begin
              if (chip_match(ish_reg[7:3], strap_lo, strap_hi)) begin // RULE_09 RULE_12
                iaddr_reg <= {ish_reg[2:1], 8'h00}; // RULE_08
                ird_reg <= ish_reg[0];
                sda_oe_n_out <= 1'b0; // RULE_06
                if (ish_reg[0]) begin
                  ist_reg <= I_RDATA;
                  iout_reg <= reg_rdata_in;
                end else begin
                  ist_reg <= I_ADDR2;
                end
              end else begin
                ist_reg <= I_IDLE;
              end
            end
            I_ADDR2: begin
              iaddr_reg <= {iaddr_reg[9:8], ish_reg}; // RULE_10
              ist_reg <= I_WDATA;
              sda_oe_n_out <= 1'b0; // RULE_06
            end
            default: begin
              iaddr_reg <= iaddr_reg + 10'h001; // RULE_11
              sda_oe_n_out <= 1'b0; // RULE_06
            end
          endcase
        end else if (ist_reg == I_RDATA && ibit_reg < 4'h8) begin
          sda_oe_n_out <= iout_reg[3'(4'h7 - ibit_reg)]; // RULE_03
        end else if (ist_reg == I_RDATA) begin
          sda_oe_n_out <= 1'b1;
          iaddr_reg <= iaddr_reg + 10'h001; // RULE_11
        end else begin
          sda_oe_n_out <= 1'b1; // RULE_03
          iack_reg <= 1'b0;
        end
      end
      if (scl_rise && ibit_reg == 4'h8 && ist_reg == I_RDATA && !sda) begin
        iout_reg <= reg_rdata_in; // RULE_20
      end
    end
  end
  assign sda_out = 1'b0;

  typedef enum {S_CHIP_ADDRESS_STRAP_HIGH, S_ADDR2, S_WDATA, S_RDATA} dsp_spi_e;
  dsp_spi_e sst_reg;
  logic [2:0] sbit_reg;
  logic [7:0] ssh_reg;
  logic [9:0] saddr_reg;
  logic [7:0] sout_reg;
  logic [7:0] sin;
  assign sin = {ssh_reg[6:0], mosi};

  // SPI follower, held in reset while select is high
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sst_reg <= S_CHIP_ADDRESS_STRAP_HIGH;
      sbit_reg <= 3'h0;
      ssh_reg <= 8'h00;
      saddr_reg <= 10'h000;
      sout_reg <= 8'h00;
      miso_out <= 1'b0;
      miso_oe_n_out <= 1'b1;
    end else if (!spi_mode || ss_n) begin
      sst_reg <= S_CHIP_ADDRESS_STRAP_HIGH; // RULE_15
      sbit_reg <= 3'h0;
      miso_oe_n_out <= 1'b1; // RULE_14
    end else begin
      if (sclk_rise) begin // RULE_13
        ssh_reg <= sin; // RULE_16
        sbit_reg <= sbit_reg + 3'h1;
        if (sbit_reg == 3'h7) begin
          case (sst_reg)
            S_CHIP_ADDRESS_STRAP_HIGH: begin
              saddr_reg <= {sin, 2'b00}; // RULE_17
              sst_reg <= S_ADDR2;
            end
            S_ADDR2: begin
              saddr_reg <= {saddr_reg[9:2], sin[7:6]}; // RULE_18
              if (sin[`DSP_SPI_DIR_BIT]) begin
                sst_reg <= S_WDATA;
              end else begin
                sst_reg <= S_RDATA;
              end
            end
            default: begin
              saddr_reg <= saddr_reg + 10'h001; // RULE_11
            end
          endcase
        end
      end
      if (sclk_fall && sst_reg == S_RDATA) begin
        miso_oe_n_out <= 1'b0; // RULE_14
        if (sbit_reg == 3'h0) begin
          miso_out <= reg_rdata_in[7]; // RULE_16
          sout_reg <= {reg_rdata_in[6:0], 1'b0};
        end else begin
          miso_out <= sout_reg[7];
          sout_reg <= {sout_reg[6:0], 1'b0};
        end
      end
    end
  end

  // Register access strobes, one cycle each
  always_comb begin
    req_wr_next = 1'b0;
    req_rd_next = 1'b0;
    req_addr_next = spi_mode ? saddr_reg : iaddr_reg;
    req_data_next = spi_mode ? sin : ish_reg;
    if (spi_mode) begin
      if (!ss_n && sclk_rise && sbit_reg == 3'h7 && sst_reg == S_WDATA) begin
        req_wr_next = 1'b1; // RULE_20
      end
      if (!ss_n && sclk_fall && sbit_reg == 3'h0 && sst_reg == S_RDATA) begin
        req_rd_next = 1'b1;
      end
    end else if (scl_fall && ibit_reg == 4'h8 && !i2c_start && !i2c_stop) begin
      req_wr_next = (ist_reg == I_WDATA); // RULE_20
      req_rd_next = (ist_reg == I_RDATA);
    end
  end
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_out <= '0;
    end else begin
      req_out <= '{wr: req_wr_next, rd: req_rd_next, addr: req_addr_next,
                   wdata: req_data_next};
    end
  end

  // Bus checks
  AST_MISO_QUIET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_14
    s2_reg[1] |=> miso_oe_n_out) else $error("MISO driven while deselected");
  AST_SPI_RESET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_15
    (spi_mode && ss_n) |=> (sst_reg == S_CHIP_ADDRESS_STRAP_HIGH && sbit_reg == 3'h0))
    else $error("SPI state not reset");
  AST_BUSY_START: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_05
    (!spi_mode && i2c_start) |=> bus_busy_out) else $error("Bus not busy after start");
  AST_IDLE_STOP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_05
    (!spi_mode && i2c_stop) |=> (!bus_busy_out && ist_reg == I_IDLE))
    else $error("Bus not idle after stop");
  AST_SDA_STABLE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_03
    (scl && s3_reg[4] && !i2c_start && !i2c_stop) |=> $stable(sda_oe_n_out))
    else $error("SDA moved while SCL high");
  AST_SPI_MODE_I2C_OFF: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_01
    spi_mode |=> sda_oe_n_out) else $error("SDA driven in SPI mode");
  AST_WR_INC: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_11
    (spi_mode && !ss_n && sclk_rise && sbit_reg == 3'h7 && sst_reg == S_WDATA)
    |=> (saddr_reg == $past(saddr_reg) + 10'h001)) else $error("SPI address not advanced");
  AST_WR_STROBE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_20
    req_out.wr |-> ##1 !req_out.wr) else $error("Write strobe too long");
  // SPI write data phase with select low
  sequence spi_wr_phase;
    spi_mode && !ss_n && sst_reg == S_WDATA;
  endsequence
  AST_SPI_WRITE_QUIET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE_14
    spi_wr_phase |-> miso_oe_n_out) else $error("MISO driven during write");
endmodule : dsp_host_port
`default_nettype wire

// ### tb/dsp_host_model.sv
// Host leader model: I2C leader and SPI leader bus cycles.
// Assumes the bench resolves SDA from both pull-downs.
`timescale 1ns/1ps
`default_nettype none
module dsp_host_model (
  input wire logic clk_in,
  input wire logic sda_in,
  input wire logic miso_in,
  input wire logic miso_oe_n_in,
  output var logic scl_out,
  output var logic sda_rel_out,
  output var logic sclk_out,
  output var logic ss_n_out,
  output var logic mosi_out
);
  logic miso_q = 1'b0;
  // Undriven MISO shows the inverse of its last level
  always @(posedge clk_in) if (!miso_oe_n_in) miso_q <= miso_in;
  wire logic miso_seen = miso_oe_n_in ? ~miso_q : miso_in;
  // Idle bus levels
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
    sclk_out = 1'b0;
    ss_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask : w
  // Start or repeated start; ends with SCL low
  task automatic i2c_start();
    w(4);
    sda_rel_out <= 1'b1;
    w(8);
    scl_out <= 1'b1;
    w(8);
    sda_rel_out <= 1'b0;
    w(8);
    scl_out <= 1'b0;
  endtask : i2c_start
  task automatic i2c_stop();
    w(4);
    sda_rel_out <= 1'b0;
    w(8);
    scl_out <= 1'b1;
    w(8);
    sda_rel_out <= 1'b1;
    w(8);
  endtask : i2c_stop
  // Nine clocks; tx[0] is the leader's acknowledge level
  task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      w(4);
      sda_rel_out <= tx[i];
      w(4);
      scl_out <= 1'b1;
      w(8);
      rx[i] = sda_in;
      scl_out <= 1'b0;
    end
  endtask : i2c_byte
  // Set select to lvl, with settle gaps before and after
  task automatic spi_sel(input logic lvl);
    w(4);
    ss_n_out <= lvl;
    w(8);
  endtask : spi_sel
  // Launch on SCLK fall, read at SCLK rise
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_out <= tx[i];
      w(4);
      sclk_out <= 1'b1;
      rx[i] = miso_seen;
      w(4);
      sclk_out <= 1'b0;
    end
  endtask : spi_byte
endmodule : dsp_host_model
`default_nettype wire

// ### tb/test_dual_serial_register_host_port.sv
// Bench for the host port: I2C and SPI register traffic.
// Assumes dsp_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_dual_serial_register_host_port;
  import dsp_pkg::*;
  logic clk = 1'b0;
  logic rst_n, interface_select_pin, st_lo, st_hi;
  logic sda_oe_n, sda_o, miso, miso_oe_n, busy, scl, sda_rel, sclk, ss_n, mosi;
  logic miso_on = 1'b0;
  dsp_req_s req;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  logic [17:0] wq[$];
  logic [9:0] rq[$];
  wire logic sda = sda_rel & (sda_oe_n | sda_o);
  wire logic [7:0] rdata = req.addr[7:0] ^ 8'hA5;
  always #2 clk = ~clk;
  dsp_host_port dut (.clk_sys_in(clk), .rst_n_in(rst_n), .interface_select_pin_in(interface_select_pin),
    .chip_address_strap_low_in(st_lo), .chip_address_strap_high_in(st_hi),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
    .sclk_in(sclk), .ss_n_in(ss_n), .mosi_in(mosi), .miso_out(miso),
    .miso_oe_n_out(miso_oe_n), .req_out(req), .reg_rdata_in(rdata), .bus_busy_out(busy));
  dsp_host_model host (.clk_in(clk), .sda_in(sda), .miso_in(miso), .miso_oe_n_in(miso_oe_n),
    .scl_out(scl), .sda_rel_out(sda_rel), .sclk_out(sclk), .ss_n_out(ss_n), .mosi_out(mosi));
  function automatic logic [7:0] exp_rd(input logic [9:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction : exp_rd
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // Write log, MISO drive monitor and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (req.wr === 1'b1) wq.push_back({req.addr, req.wdata});
    if (req.rd === 1'b1) rq.push_back(req.addr);
    if (miso_oe_n === 1'b0) miso_on <= 1'b1;
    if (cyc == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr_chk(input logic [9:0] a, input logic [7:0] d);
    logic [17:0] got;
    got = (wq.size() != 0) ? wq.pop_front() : 18'h3FFFF;
    chk(got, {a, d}, "write");
  endtask : wr_chk
  task automatic rd_chk(input logic [9:0] a);
    logic [9:0] got;
    got = (rq.size() != 0) ? rq.pop_front() : 10'h3FF;
    chk(18'(got), 18'(a), "read strobe");
  endtask : rd_chk
  task automatic iw(input logic [7:0] b, input logic ack);
    logic [8:0] rx;
    host.i2c_byte({b, 1'b1}, rx);
    chk(18'(rx[0]), 18'(ack), "ack");
  endtask : iw
  task automatic t_i2c_write();
    st_hi <= 1'b1;
    host.i2c_start();
    chk(18'(busy), 18'h1, "busy");
    iw({5'h12, 2'h1, 1'b0}, 1'b0);
    iw(8'hFE, 1'b0);
    iw(8'h3C, 1'b0);
    iw(8'hC3, 1'b0);
    host.i2c_start();
    iw({5'h15, 2'h2, 1'b0}, 1'b0);
    iw(8'h10, 1'b0);
    iw(8'h77, 1'b0);
    host.i2c_stop();
    chk(18'(busy), 18'h0, "idle");
    wr_chk(10'h1FE, 8'h3C);
    wr_chk(10'h1FF, 8'hC3);
    wr_chk(10'h210, 8'h77);
    $display("test i2c write done");
  endtask : t_i2c_write
  task automatic t_i2c_miss();
    st_hi <= 1'b0;
    st_lo <= 1'b1;
    host.i2c_start();
    iw({5'h12, 2'h0, 1'b0}, 1'b1);
    iw(8'h00, 1'b1);
    host.i2c_stop();
    chk(18'(wq.size()), 18'h0, "stray write");
    $display("test i2c miss done");
  endtask : t_i2c_miss
  task automatic t_i2c_read();
    logic [8:0] rx;
    host.i2c_start();
    iw({5'h11, 2'h3, 1'b1}, 1'b0);
    host.i2c_byte({8'hFF, 1'b0}, rx);
    chk(18'(rx[8:1]), 18'(exp_rd(10'h300)), "read 0");
    host.i2c_byte({8'hFF, 1'b1}, rx);
    chk(18'(rx[8:1]), 18'(exp_rd(10'h301)), "read 1");
    host.i2c_stop();
    rd_chk(10'h300);
    rd_chk(10'h301);
    $display("test i2c read done");
  endtask : t_i2c_read
  task automatic t_spi_write();
    logic [7:0] rx;
    interface_select_pin <= 1'b1;
    miso_on = 1'b0;
    host.spi_sel(1'b0);
    host.spi_byte(8'hFF, rx);
    host.spi_sel(1'b1);
    host.spi_sel(1'b0);
    host.spi_byte(8'hAA, rx);
    host.spi_byte(8'hF5, rx);
    host.spi_byte(8'h11, rx);
    host.spi_byte(8'h22, rx);
    host.spi_sel(1'b1);
    wr_chk(10'h2AB, 8'h11);
    wr_chk(10'h2AC, 8'h22);
    chk(18'(miso_on), 18'h0, "miso in write");
    $display("test spi write done");
  endtask : t_spi_write
  task automatic t_spi_read();
    logic [7:0] rx;
    host.spi_sel(1'b0);
    host.spi_byte(8'h3F, rx);
    host.spi_byte(8'hDF, rx);
    host.spi_byte(8'h00, rx);
    chk(18'(rx), 18'(exp_rd(10'h0FF)), "spi read 0");
    host.spi_byte(8'h00, rx);
    chk(18'(rx), 18'(exp_rd(10'h100)), "spi read 1");
    chk(18'(miso_on), 18'h1, "miso in read");
    host.spi_sel(1'b1);
    chk(18'(miso_oe_n), 18'h1, "miso released");
    rd_chk(10'h0FF);
    rd_chk(10'h100);
    rd_chk(10'h101);
    $display("test spi read done");
  endtask : t_spi_read
  // Reset for three cycles, then the scenarios
  initial begin
    rst_n <= 1'b0;
    interface_select_pin <= 1'b0;
    st_lo <= 1'b0;
    st_hi <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_i2c_write();
    t_i2c_miss();
    t_i2c_read();
    t_spi_write();
    t_spi_read();
    report_and_stop();
  end
endmodule : test_dual_serial_register_host_port
`default_nettype wire
